// *** verilog/awe_pkg.sv ***
// Shared constants and types of the ATA write command engine
package awe_pkg;
    localparam logic [7:0] AWE_OFS_FEATURE = 8'h00;
    localparam logic [7:0] AWE_OFS_COUNT = 8'h04;
    localparam logic [7:0] AWE_OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] AWE_OFS_ADDR_MID = 8'h0C;
    localparam logic [7:0] AWE_OFS_ADDR_HIGH = 8'h10;
    localparam logic [7:0] AWE_OFS_UNIT = 8'h14;
    localparam logic [7:0] AWE_OFS_CMD_STAT = 8'h18;
    localparam logic [7:0] AWE_OFS_BLOCK_SIZE = 8'h1C;
    localparam logic [7:0] AWE_OFS_ERROR = 8'h20;
    localparam logic [7:0] AWE_OFS_INT_STAT = 8'h24;
    localparam logic [7:0] AWE_OFS_INT_MASK = 8'h28;

    localparam logic [7:0] AWE_CMD_WRITE_SECT = 8'h30;
    localparam logic [7:0] AWE_CMD_WRITE_SECT_NR = 8'h31;
    localparam logic [7:0] AWE_CMD_WRITE_SECT_EXT = 8'h34;
    localparam logic [7:0] AWE_CMD_WRITE_MULT_EXT = 8'h39;
    localparam logic [7:0] AWE_CMD_WRITE_MULT_FUA = 8'hCE;

    localparam int AWE_UNIT_LBA_BIT = 6;
    localparam int AWE_UNIT_SEL_BIT = 4;
    localparam int AWE_ST_BUSY = 7;
    localparam int AWE_ST_READY = 6;
    localparam int AWE_ST_DRQ = 3;
    localparam int AWE_ST_ERR = 0;
    localparam int AWE_ERR_MEDIA = 6;
    localparam int AWE_ERR_ABORT = 2;
    localparam int AWE_INT_BLOCK = 0;
    localparam int AWE_INT_DONE = 1;
    localparam int AWE_INT_ERR = 2;
    localparam int AWE_INT_W = 3;

    localparam logic [7:0] AWE_BYTE_RESET = 8'h00;
    localparam logic [16:0] AWE_COUNT_MAX48 = 17'h10000;
    localparam logic [16:0] AWE_COUNT_MAX28 = 17'h00100;

    typedef struct packed {
        logic valid;
        logic fua;
        logic [47:0] lba;
    } awe_media_s;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } awe_data_s;
endpackage : awe_pkg

// *** verilog/awe_write_engine.sv ***
// ATA write command engine: task file, block pacing and media commit
//
// Operation
// - Block write interrupts once per block of set-multiple size.
// - Data request held for the whole block.
// - Count register holds total sectors, not blocks.
// - Full blocks, then one partial block of count mod size.
// - Media error reported after the block write attempt.
// - Media error stops at failing sector; no further blocks.
// - Interrupt at data request of each block but the first.
// - 48-bit count: previous bits 15-8, current bits 7-0.
// - 48-bit address: previous bits 47-24, current bits 23-0.
// - Decode 34h sector ext, 39h block ext, CEh forced block.
// - CEh commits to media before ending status, else as 39h.
// - 30h/31h write sectors from the address registers.
// - 28-bit: mode bit picks cylinder/head/sector or logical.
// - 28-bit completion leaves last sector address.
// - 28-bit failure stops, leaves failing sector address.
// - 48-bit completion leaves last sector's full address.
// - 48-bit failure stops, leaves failing sector's full address.
`timescale 1ns/1ps
`default_nettype none
module awe_write_engine #(
    parameter int SECTOR_WORDS = 256,
    parameter int HEADS = 16,
    parameter int TRACK_SECTORS = 63
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire awe_pkg::awe_data_s host_data,
    output logic host_data_ready,
    output awe_pkg::awe_data_s media_data,
    output awe_pkg::awe_media_s media_req,
    input wire logic media_ack,
    input wire logic media_fail,
    output logic irq
);
    import awe_pkg::*;

    typedef enum logic [2:0] {
        AWE_IDLE, AWE_XFER, AWE_COMMIT, AWE_WAIT
    } awe_state_e;

    localparam int WCNT_W = $clog2(SECTOR_WORDS + 1);
    localparam logic [WCNT_W-1:0] LAST_WORD = WCNT_W'(SECTOR_WORDS - 1);
    localparam logic [7:0] LAST_HEAD = 8'(HEADS - 1);
    localparam logic [7:0] LAST_SECT = 8'(TRACK_SECTORS);

    // Next sector address
    function automatic logic [47:0] awe_next_addr(input logic lba_mode,
                                                  input logic ext,
                                                  input logic [47:0] a);
        logic [47:0] r;
        r = a + 48'h1;
        if (!ext && !lba_mode) begin
            r = a;
            if (a[7:0] < LAST_SECT) begin
                r[7:0] = a[7:0] + 8'h01;
            end else begin
                r[7:0] = 8'h01;
                if ({4'h0, a[27:24]} < LAST_HEAD) begin
                    r[27:24] = a[27:24] + 4'h1;
                end else begin
                    r[27:24] = 4'h0;
                    r[23:8] = a[23:8] + 16'h0001;
                end
            end
        end
        return r;
    endfunction : awe_next_addr

    awe_state_e state_q, state_d;
    logic [7:0] feat_q [2];
    logic [7:0] cnt_q [2];
    logic [7:0] low_q [2];
    logic [7:0] mid_q [2];
    logic [7:0] high_q [2];
    logic [7:0] unit_q, blk_size_q, err_q, blk_len_q;
    logic [AWE_INT_W-1:0] int_stat_q, int_mask_q, int_set;
    logic [47:0] addr_q, addr_d;
    logic [16:0] remain_q, remain_d;
    logic [7:0] blk_left_q, blk_left_d;
    logic [WCNT_W-1:0] word_q, word_d;
    logic ext_q, ext_d, fua_q, fua_d, lba_mode_q, lba_mode_d;
    logic err_flag_q, err_flag_d, wb_q, wb_d, mult_q;
    logic [7:0] err_d;
    logic [31:0] rdata_d;
    logic ready_d, req_valid_d;
    awe_data_s media_data_d;

    wire wr_feat = reg_wr && reg_addr == AWE_OFS_FEATURE;
    wire wr_cnt = reg_wr && reg_addr == AWE_OFS_COUNT;
    wire wr_low = reg_wr && reg_addr == AWE_OFS_ADDR_LOW;
    wire wr_mid = reg_wr && reg_addr == AWE_OFS_ADDR_MID;
    wire wr_high = reg_wr && reg_addr == AWE_OFS_ADDR_HIGH;
    wire wr_unit = reg_wr && reg_addr == AWE_OFS_UNIT;
    wire wr_cmd = reg_wr && reg_addr == AWE_OFS_CMD_STAT;
    wire wr_bsz = reg_wr && reg_addr == AWE_OFS_BLOCK_SIZE;
    wire wr_istat = reg_wr && reg_addr == AWE_OFS_INT_STAT;
    wire wr_imask = reg_wr && reg_addr == AWE_OFS_INT_MASK;
    wire [7:0] cmd = reg_wdata[7:0];
    wire idle = state_q == AWE_IDLE;
    wire start = wr_cmd && idle;
    // Command decode
    wire is_mult = cmd == AWE_CMD_WRITE_MULT_EXT
                || cmd == AWE_CMD_WRITE_MULT_FUA;
    wire is_ext = is_mult || cmd == AWE_CMD_WRITE_SECT_EXT;
    wire is_known = is_ext || cmd == AWE_CMD_WRITE_SECT
                 || cmd == AWE_CMD_WRITE_SECT_NR;
    // No block size: abort
    wire bad_bsz = is_mult && blk_size_q == 8'h00;
    // 16-bit count
    wire [15:0] cnt16 = {cnt_q[1], cnt_q[0]};
    wire [16:0] cnt48 = cnt16 == 16'h0000 ? AWE_COUNT_MAX48
                                          : {1'b0, cnt16};
    wire [16:0] cnt28 = cnt_q[0] == 8'h00 ? AWE_COUNT_MAX28
                                          : {9'h000, cnt_q[0]};
    wire [47:0] lba48 = {high_q[1], mid_q[1], low_q[1],
                         high_q[0], mid_q[0], low_q[0]};
    wire [47:0] lba28 = {20'h00000, unit_q[3:0],
                         high_q[0], mid_q[0], low_q[0]};
    wire [16:0] start_cnt = is_ext ? cnt48 : cnt28;
    // Block length
    wire [7:0] blk_len = is_mult ? blk_size_q : 8'h01;
    // First block length
    wire [7:0] first_blk = start_cnt < {9'h000, blk_len}
                         ? start_cnt[7:0] : blk_len;
    wire [16:0] remain_next = remain_q - 17'h00001;
    wire [7:0] next_blk = remain_next < {9'h000, blk_size_q}
                        ? remain_next[7:0] : blk_size_q;
    wire accept = host_data.valid && host_data_ready;
    wire last_word = word_q == LAST_WORD;
    wire blk_in_done = accept && last_word && blk_left_q == 8'h01;
    wire [7:0] status = {!idle, idle, 3'b000,
                         host_data_ready, 2'b00} | {7'h00, err_flag_q};

    // Read data decode
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (reg_addr)
            AWE_OFS_FEATURE: rdata_d = {16'h0000, feat_q[1], feat_q[0]};
            AWE_OFS_COUNT: rdata_d = {16'h0000, cnt_q[1], cnt_q[0]};
            AWE_OFS_ADDR_LOW: rdata_d = {16'h0000, low_q[1], low_q[0]};
            AWE_OFS_ADDR_MID: rdata_d = {16'h0000, mid_q[1], mid_q[0]};
            AWE_OFS_ADDR_HIGH: rdata_d = {16'h0000, high_q[1], high_q[0]};
            AWE_OFS_UNIT: rdata_d = {24'h000000, unit_q};
            AWE_OFS_CMD_STAT: rdata_d = {24'h000000, status};
            AWE_OFS_BLOCK_SIZE: rdata_d = {24'h000000, blk_size_q};
            AWE_OFS_ERROR: rdata_d = {24'h000000, err_q};
            AWE_OFS_INT_STAT: rdata_d = {29'h0, int_stat_q};
            AWE_OFS_INT_MASK: rdata_d = {29'h0, int_mask_q};
            default: rdata_d = 32'h0000_0000;
        endcase
        if (!reg_rd) begin
            rdata_d = 32'h0000_0000;
        end
    end

    // Command sequencer
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        remain_d = remain_q;
        blk_left_d = blk_left_q;
        word_d = word_q;
        ext_d = ext_q;
        fua_d = fua_q;
        lba_mode_d = lba_mode_q;
        err_flag_d = err_flag_q;
        err_d = err_q;
        wb_d = 1'b0;
        int_set = '0;
        ready_d = 1'b0;
        req_valid_d = media_req.valid;
        case (state_q)
            AWE_IDLE: begin
                if (start) begin
                    err_d = 8'h00;
                    err_flag_d = 1'b0;
                    if (!is_known || bad_bsz) begin
                        err_d[AWE_ERR_ABORT] = 1'b1;
                        err_flag_d = 1'b1;
                        int_set[AWE_INT_ERR] = 1'b1;
                        int_set[AWE_INT_DONE] = 1'b1;
                    end else begin
                        ext_d = is_ext;
                        fua_d = cmd == AWE_CMD_WRITE_MULT_FUA;
                        lba_mode_d = unit_q[AWE_UNIT_LBA_BIT];
                        addr_d = is_ext ? lba48 : lba28;
                        remain_d = start_cnt;
                        blk_left_d = first_blk;
                        word_d = '0;
                        // No interrupt on first block
                        ready_d = 1'b1;
                        state_d = AWE_XFER;
                    end
                end
            end
            AWE_XFER: begin
                // Request held for whole block
                ready_d = !blk_in_done;
                if (accept) begin
                    word_d = last_word ? '0 : word_q + WCNT_W'(1);
                    if (last_word) begin
                        blk_left_d = blk_left_q - 8'h01;
                    end
                end
                if (blk_in_done) begin
                    blk_left_d = blk_len_q;
                    state_d = AWE_COMMIT;
                end
            end
            AWE_COMMIT: begin
                req_valid_d = 1'b1;
                state_d = AWE_WAIT;
            end
            AWE_WAIT: begin
                if (media_ack) begin
                    req_valid_d = 1'b0;
                    if (media_fail) begin
                        // Stop at failing sector
                        err_d[AWE_ERR_MEDIA] = 1'b1;
                        err_flag_d = 1'b1;
                        wb_d = 1'b1;
                        int_set[AWE_INT_ERR] = 1'b1;
                        int_set[AWE_INT_DONE] = 1'b1;
                        state_d = AWE_IDLE;
                    end else if (remain_next == 17'h00000) begin
                        // Media ack carries the forced commit for CEh
                        wb_d = 1'b1;
                        int_set[AWE_INT_DONE] = 1'b1;
                        state_d = AWE_IDLE;
                    end else begin
                        remain_d = remain_next;
                        addr_d = awe_next_addr(lba_mode_q, ext_q, addr_q);
                        blk_left_d = blk_left_q - 8'h01;
                        state_d = AWE_COMMIT;
                        if (blk_left_q == 8'h01) begin
                            blk_left_d = ext_q && mult_q
                                       ? next_blk : 8'h01;
                            ready_d = 1'b1;
                            // Later blocks interrupt at request
                            int_set[AWE_INT_BLOCK] = 1'b1;
                            state_d = AWE_XFER;
                        end
                    end
                end
            end
            default: state_d = AWE_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_len_q <= 8'h00;
            mult_q <= 1'b0;
        end else if (start) begin
            blk_len_q <= first_blk;
            mult_q <= is_mult;
        end else if (state_q == AWE_WAIT && state_d == AWE_XFER) begin
            blk_len_q <= blk_left_d;
        end
    end

    assign media_data_d = '{valid: accept, word: host_data.word};

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= AWE_IDLE;
            addr_q <= '0;
            remain_q <= '0;
            blk_left_q <= 8'h00;
            word_q <= '0;
            ext_q <= 1'b0;
            fua_q <= 1'b0;
            lba_mode_q <= 1'b0;
            err_flag_q <= 1'b0;
            err_q <= 8'h00;
            wb_q <= 1'b0;
            host_data_ready <= 1'b0;
            media_data <= '0;
            media_req <= '0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            remain_q <= remain_d;
            blk_left_q <= blk_left_d;
            word_q <= word_d;
            ext_q <= ext_d;
            fua_q <= fua_d;
            lba_mode_q <= lba_mode_d;
            err_flag_q <= err_flag_d;
            err_q <= err_d;
            wb_q <= wb_d;
            host_data_ready <= ready_d;
            media_data <= media_data_d;
            media_req <= '{valid: req_valid_d, fua: fua_d, lba: addr_d};
            reg_rdata <= rdata_d;
        end
    end

    // Task file bytes: a write moves current to previous
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 2; i++) begin
                feat_q[i] <= AWE_BYTE_RESET;
                cnt_q[i] <= AWE_BYTE_RESET;
                low_q[i] <= AWE_BYTE_RESET;
                mid_q[i] <= AWE_BYTE_RESET;
                high_q[i] <= AWE_BYTE_RESET;
            end
            unit_q <= AWE_BYTE_RESET;
            blk_size_q <= AWE_BYTE_RESET;
        end else if (wb_q) begin
            // Last or failing sector address
            low_q <= '{addr_q[7:0], addr_q[31:24]};
            mid_q <= '{addr_q[15:8], addr_q[39:32]};
            high_q <= '{addr_q[23:16], addr_q[47:40]};
            if (!ext_q) begin
                unit_q[3:0] <= addr_q[27:24];
            end
        end else begin
            if (wr_feat) feat_q <= '{reg_wdata[7:0], feat_q[0]};
            if (wr_cnt) cnt_q <= '{reg_wdata[7:0], cnt_q[0]};
            if (wr_low) low_q <= '{reg_wdata[7:0], low_q[0]};
            if (wr_mid) mid_q <= '{reg_wdata[7:0], mid_q[0]};
            if (wr_high) high_q <= '{reg_wdata[7:0], high_q[0]};
            if (wr_unit) unit_q <= reg_wdata[7:0];
            if (wr_bsz && idle) blk_size_q <= reg_wdata[7:0];
        end
    end

    // Sticky events, write one to clear; a new event wins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_q <= '0;
            int_mask_q <= '0;
            irq <= 1'b0;
        end else begin
            int_stat_q <= (int_stat_q
                          & ~(wr_istat ? reg_wdata[AWE_INT_W-1:0] : '0))
                          | int_set;
            if (wr_imask) int_mask_q <= reg_wdata[AWE_INT_W-1:0];
            irq <= |((int_stat_q | int_set) & int_mask_q);
        end
    end
endmodule : awe_write_engine
`default_nettype wire

// *** verification/awe_write_engine_assertions.sv ***
// Port checker for the ATA write command engine
`timescale 1ns/1ps
`default_nettype none
module awe_write_engine_chk
    import awe_pkg::*;
#(
    parameter int SECTOR_WORDS = 256
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire awe_pkg::awe_data_s host_data,
    input wire logic host_data_ready,
    input wire awe_pkg::awe_data_s media_data,
    input wire awe_pkg::awe_media_s media_req,
    input wire logic media_ack,
    input wire logic media_fail,
    input wire logic irq
);
    logic [7:0] cmd_q;
    logic [7:0] bs_q;
    logic [31:0] wcnt_q;
    wire take = host_data.valid && host_data_ready;
    wire idle = !host_data_ready && !media_req.valid;
    wire cmd_wr = reg_wr && reg_addr == AWE_OFS_CMD_STAT;
    wire bs_wr = reg_wr && reg_addr == AWE_OFS_BLOCK_SIZE;
    wire blk = cmd_q inside {AWE_CMD_WRITE_MULT_EXT, AWE_CMD_WRITE_MULT_FUA};
    wire blk_wd = reg_wdata[7:0] inside
        {AWE_CMD_WRITE_MULT_EXT, AWE_CMD_WRITE_MULT_FUA};
    wire [31:0] lim = 32'(SECTOR_WORDS) * (blk ? 32'(bs_q) : 32'h1);

    // Command, block size, words in window
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_q <= 8'h00;
            bs_q <= 8'h00;
            wcnt_q <= 32'h0;
        end else begin
            if (cmd_wr && idle) cmd_q <= reg_wdata[7:0];
            if (bs_wr && idle) bs_q <= reg_wdata[7:0];
            wcnt_q <= !host_data_ready ? 32'h0 : wcnt_q + 32'(take);
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("stray read data");
    AST_ECHO: assert property (take |=> media_data.valid
        && media_data.word == $past(host_data.word))
        else $error("word lost");
    AST_NO_ECHO: assert property (!take |=> !media_data.valid)
        else $error("stray word");
    AST_BLOCK_END: assert property (take && wcnt_q == lim - 1
        |=> !host_data_ready) else $error("request outlives block");
    AST_BLOCK_MAX: assert property (host_data_ready
        |-> wcnt_q < lim) else $error("block too long");
    AST_AFTER_BLOCK: assert property (host_data_ready
        |-> !media_req.valid) else $error("media write during block");
    AST_REQ_HOLD: assert property (media_req.valid && !media_ack
        |=> media_req.valid && $stable(media_req.lba))
        else $error("request changed");
    AST_REQ_DROP: assert property (media_req.valid && media_ack
        |=> !media_req.valid) else $error("media request not dropped");
    AST_FAIL_STOP: assert property (media_req.valid && media_ack
        && media_fail |=> (!host_data_ready && !media_req.valid) [*8])
        else $error("activity after fail");
    AST_FUA: assert property (media_req.valid
        |-> media_req.fua == (cmd_q == AWE_CMD_WRITE_MULT_FUA))
        else $error("forced commit flag wrong");
    AST_ABORT: assert property (cmd_wr && idle && !bs_q && blk_wd
        |=> !host_data_ready [*4]) else $error("request without block size");
endmodule : awe_write_engine_chk

bind awe_write_engine awe_write_engine_chk #(.SECTOR_WORDS(SECTOR_WORDS)) u_chk (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .host_data(host_data),
    .host_data_ready(host_data_ready), .media_data(media_data),
    .media_req(media_req), .media_ack(media_ack),
    .media_fail(media_fail), .irq(irq));
`default_nettype wire

// *** verification/awe_far_model.sv ***
// Host word source and media responder
`timescale 1ns/1ps
`default_nettype none
module awe_far_model
    import awe_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic host_data_ready,
    input wire awe_pkg::awe_media_s media_req,
    input wire logic fail_en,
    input wire logic [47:0] fail_lba,
    input wire logic slow,
    output awe_pkg::awe_data_s host_data,
    output logic media_ack,
    output logic media_fail
);
    logic [1:0] dly_q;
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            host_data <= '0;
            media_ack <= 1'b0;
            media_fail <= 1'b0;
            dly_q <= 2'h0;
        end else begin
            // Stream while requested
            if (host_data_ready && !(slow && 1'($urandom))) begin
                host_data.valid <= 1'b1;
                host_data.word <= 16'($urandom);
            end else begin
                host_data.valid <= 1'b0;
                host_data.word <= ~host_data.word;
            end
            media_ack <= 1'b0;
            media_fail <= ~media_fail;
            if (media_req.valid && !media_ack) begin
                if (dly_q == 2'h0) begin
                    media_ack <= 1'b1;
                    media_fail <= fail_en && media_req.lba == fail_lba;
                    dly_q <= slow ? 2'($urandom) : 2'h0;
                end else begin
                    dly_q <= dly_q - 2'h1;
                end
            end
        end
    end
endmodule : awe_far_model
`default_nettype wire

// *** verification/awe_write_engine_test.sv ***
// Bench for the ATA write command engine
`timescale 1ns/1ps
`default_nettype none
module awe_write_engine_test;
    import awe_pkg::*;
    localparam int SW = 2;
    logic core_clk, rst_n, reg_wr, reg_rd, media_ack, media_fail, irq;
    logic host_data_ready, fail_en, slow, rdy_q;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [47:0] fail_lba;
    awe_data_s host_data, media_data;
    awe_media_s media_req;
    int bad_count, checks, wc, bs, cn, fx;
    int win_q[$];
    logic [47:0] lba_q[$];

    awe_write_engine #(.SECTOR_WORDS(SW)) uut (.core_clk(core_clk),
        .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_data(host_data), .host_data_ready(host_data_ready),
        .media_data(media_data), .media_req(media_req),
        .media_ack(media_ack), .media_fail(media_fail), .irq(irq));
    awe_far_model far (.core_clk(core_clk), .rst_n(rst_n),
        .host_data_ready(host_data_ready), .media_req(media_req),
        .fail_en(fail_en), .fail_lba(fail_lba), .slow(slow),
        .host_data(host_data), .media_ack(media_ack),
        .media_fail(media_fail));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    // Words per request window, sectors written
    always @(posedge core_clk) begin
        if (host_data_ready && host_data.valid) wc++;
        if (rdy_q && !host_data_ready) begin
            win_q.push_back(wc);
            wc = 0;
        end
        rdy_q = host_data_ready;
        if (media_req.valid && media_ack) lba_q.push_back(media_req.lba);
    end

    task automatic chk(input string nm, input logic [47:0] got,
        input logic [47:0] want);
        checks++;
        if (got !== want) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, want, got);
        end
    endtask : chk

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= {24'h0, d};
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd

    task automatic ichk(input logic [2:0] e);
        logic [31:0] d;
        rd(AWE_OFS_INT_STAT, d);
        chk("int status", d[2:0], e);
        chk("irq", irq, 1'b1);
        wr(AWE_OFS_INT_STAT, 8'h07);
        rd(AWE_OFS_INT_STAT, d);
        chk("int clear", d[2:0], 3'h0);
        chk("irq clear", irq, 1'b0);
    endtask : ichk

    task automatic run(input logic [7:0] cmd, input logic [15:0] cnt,
        input logic [47:0] lba, input logic [7:0] unit, input int bs,
        input int fx);
        logic [31:0] d;
        logic [47:0] last;
        logic ext, blk;
        int sent, k, nw, ns;
        blk = cmd inside {AWE_CMD_WRITE_MULT_EXT, AWE_CMD_WRITE_MULT_FUA};
        ext = blk || cmd == AWE_CMD_WRITE_SECT_EXT;
        fail_en <= fx >= 0;
        fail_lba <= lba + 48'(fx);
        if (blk && bs > 0) wr(AWE_OFS_BLOCK_SIZE, 8'(bs));
        wr(AWE_OFS_INT_STAT, 8'h07);
        for (int j = 0; j < 3; j++) begin
            wr(8'(AWE_OFS_ADDR_LOW + 4 * j), lba[31 + 8 * j -: 8]);
            wr(8'(AWE_OFS_ADDR_LOW + 4 * j), lba[7 + 8 * j -: 8]);
        end
        wr(AWE_OFS_COUNT, cnt[15:8]);
        wr(AWE_OFS_COUNT, cnt[7:0]);
        wr(AWE_OFS_UNIT, unit);
        win_q.delete();
        lba_q.delete();
        wr(AWE_OFS_CMD_STAT, cmd);
        for (int i = 0; i < 3000; i++) begin
            rd(AWE_OFS_CMD_STAT, d);
            if (d[AWE_ST_BUSY] === 1'b0 && d[AWE_ST_DRQ] === 1'b0) break;
            if (i == 2999) begin
                bad_count++;
                close_out();
            end
        end
        sent = 0;
        nw = 0;
        while (sent < cnt && (fx < 0 || sent <= fx) && (bs > 0 || !blk)) begin
            k = !blk ? 1 : (cnt - sent < bs) ? cnt - sent : bs;
            chk("block words", nw < win_q.size() ? win_q[nw] : -1,
                k * SW);
            sent += k;
            nw++;
        end
        chk("blocks", win_q.size(), nw);
        ns = fx < 0 ? sent : fx + 1;
        chk("sectors", lba_q.size(), ns);
        for (int i = 0; i < ns && i < lba_q.size(); i++)
            if (ext || unit[AWE_UNIT_LBA_BIT])
                chk("lba", lba_q[i], lba + 48'(i));
        last = lba + 48'(ns - 1);
        rd(AWE_OFS_CMD_STAT, d);
        chk("error bit", d[AWE_ST_ERR], ns == 0 || fx >= 0);
        rd(AWE_OFS_ERROR, d);
        if (ns == 0) chk("abort", d[AWE_ERR_ABORT], 1'b1);
        if (fx >= 0) chk("media err", d[AWE_ERR_MEDIA], 1'b1);
        for (int j = 0; j < 3 && ns > 0; j++) begin
            rd(8'(AWE_OFS_ADDR_LOW + 4 * j), d);
            chk("addr", ext ? d[15:0] : d[7:0],
                ext ? {last[31 + 8 * j -: 8], last[7 + 8 * j -: 8]}
                    : last[7 + 8 * j -: 8]);
        end
        if (!ext) begin
            rd(AWE_OFS_UNIT, d);
            chk("unit", d[3:0], last[27:24]);
        end
        $display("test done: cmd %h count %0d", cmd, cnt);
    endtask : run

    initial begin
        logic [31:0] d;
        logic [47:0] a;
        rst_n = 1'b0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, fail_en, fail_lba} = '0;
        {slow, rdy_q} = 2'b00;
        void'($urandom(4466));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(AWE_OFS_CMD_STAT, d);
        chk("status reset", d, 32'h40);
        rd(AWE_OFS_BLOCK_SIZE, d);
        chk("block size reset", d, 32'h0);
        rd(8'h3C, d);
        chk("unmapped", d, 32'h0);
        wr(AWE_OFS_COUNT, 8'hA5);
        wr(AWE_OFS_COUNT, 8'h3C);
        rd(AWE_OFS_COUNT, d);
        chk("count pair", d[15:0], 16'hA53C);
        $display("test registers done");
        wr(AWE_OFS_INT_MASK, 8'h07);
        run(AWE_CMD_WRITE_MULT_EXT, 16'h0004, 48'h1000, 8'h40, 0, -1);
        a = {16'($urandom), 32'($urandom)};
        run(AWE_CMD_WRITE_MULT_EXT, 16'h000A, a, 8'h40, 4, -1);
        ichk(3'b011);
        run(AWE_CMD_WRITE_MULT_EXT, 16'h0004, a, 8'h40, 4, -1);
        ichk(3'b010);
        run(AWE_CMD_WRITE_MULT_FUA, 16'h0003, a, 8'h40, 2, -1);
        ichk(3'b011);
        run(AWE_CMD_WRITE_SECT_EXT, 16'h0003, a, 8'h40, 1, -1);
        ichk(3'b011);
        run(AWE_CMD_WRITE_MULT_EXT, 16'h0102, a, 8'h40, 8, -1);
        run(AWE_CMD_WRITE_MULT_EXT, 16'h000A, a, 8'h40, 4, 5);
        a = 48'(28'($urandom));
        run(AWE_CMD_WRITE_SECT, 16'h0002, a, 8'h40 | 8'(a[27:24]), 1, -1);
        run(AWE_CMD_WRITE_SECT_NR, 16'h0003, a, 8'h40 | 8'(a[27:24]), 1, 1);
        run(AWE_CMD_WRITE_SECT, 16'h0001, 48'h0300_1205, 8'h03, 1, -1);
        wr(AWE_OFS_INT_MASK, 8'h00);
        run(AWE_CMD_WRITE_SECT_EXT, 16'h0002, a, 8'h40, 1, -1);
        chk("irq masked", irq, 1'b0);
        wr(AWE_OFS_INT_MASK, 8'h07);
        ichk(3'b011);
        slow <= 1'b1;
        for (int n = 0; n < 5; n++) begin
            bs = $urandom_range(4, 1);
            cn = $urandom_range(12, 1);
            fx = ($urandom % 3 == 0) ? $urandom_range(cn - 1, 0) : -1;
            a = {16'($urandom), 32'($urandom)};
            run(n % 2 ? AWE_CMD_WRITE_MULT_FUA : AWE_CMD_WRITE_MULT_EXT,
                16'(cn), a, 8'h40, bs, fx);
        end
        close_out();
    end
endmodule : awe_write_engine_test
`default_nettype wire
